/* drs_regs.svh */
// register offsets, field positions, reset values and timing figures of the driver control
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH

// register byte offsets
`define DRS_OFF_CUR_ONE     8'h00
`define DRS_OFF_CUR_TWO     8'h04
`define DRS_OFF_SLEW        8'h08
`define DRS_OFF_FAULT       8'h0C
`define DRS_OFF_STATE       8'h10
`define DRS_OFF_IRQ_ST      8'h14
`define DRS_OFF_IRQ_MASK    8'h18

// reset values
`define DRS_CUR_RST         10'h000
`define DRS_SLEW_RST        2'h0
`define DRS_FAULT_RST       4'h0
`define DRS_IRQ_RST         8'h00
`define DRS_RDATA_RST       32'h0000_0000
`define DRS_SYNC_RST        6'h2A

// synchroniser bit positions
`define DRS_SY_SCK          0
`define DRS_SY_CSB          1
`define DRS_SY_SI           2
`define DRS_SY_SAFE         3
`define DRS_SY_TEST         4
`define DRS_SY_SUPLO        5

// serial frame layout, msb first
`define DRS_FRAME_BITS      5'h10
`define DRS_FR_SEL_HI       15
`define DRS_FR_SEL_LO       14
`define DRS_FR_DATA_HI      9
`define DRS_FR_SLEW_HI      1
`define DRS_SEL_CUR_ONE     2'h0
`define DRS_SEL_CUR_TWO     2'h1
`define DRS_SEL_SLEW        2'h2

// state register bits
`define DRS_ST_SAFE         0
`define DRS_ST_TEST         1
`define DRS_ST_CMD          2
`define DRS_ST_SUPLO        3

// interrupt status bits; faults occupy bits 3..0
`define DRS_IRQ_SAFE_IN     4
`define DRS_IRQ_SAFE_OUT    5
`define DRS_IRQ_FRAME_OK    6
`define DRS_IRQ_FRAME_DROP  7

// typical output transition times per slew code, and the clock period
`define DRS_SLEW_T0_NS      500
`define DRS_SLEW_T1_NS      1000
`define DRS_SLEW_T2_NS      2000
`define DRS_SLEW_T3_NS      5000
`define DRS_CLK_PERIOD_PS   8000

`endif

/* drs_pkg.sv */
// types shared by the driver reset and safe-state control
package drs_pkg;

    // serial receiver states, one-hot
    typedef enum logic [2:0] {
        DRS_LNK_IDLE  = 3'h1,
        DRS_LNK_SHIFT = 3'h2,
        DRS_LNK_HOLD  = 3'h4
    } drs_lnk_state_t;

    // serial receiver state
    typedef struct packed {
        drs_lnk_state_t state;
        logic           sck_d;
        logic [4:0]     bitcnt;
        logic [15:0]    shift_in;
        logic [15:0]    shift_out;
        logic           so;
        logic           so_oe_n;
        logic           frame_valid;
        logic           frame_drop;
        logic [15:0]    frame_data;
    } drs_lnk_st_t;

    // top-level state
    typedef struct packed {
        logic [9:0]  cur1;
        logic [9:0]  cur2;
        logic [1:0]  slew;
        logic        cmd_valid;
        logic [3:0]  fault;
        logic [7:0]  irq_st;
        logic [7:0]  irq_mask;
        logic        safe_d;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
        logic        drv1;
        logic        drv2;
        logic [9:0]  slew_cyc;
    } drs_top_st_t;

endpackage

/* drs_sync.sv */
// three-stage input synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`include "drs_regs.svh"

module drs_sync #(
    parameter int               W       = 6,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           clock,
    input  wire logic           rst_n,
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } drs_sync_st_t;

    drs_sync_st_t s_r;
    drs_sync_st_t s_nxt;

    // stage one feeds only stage two; output follows stage three when two and three agree
    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        for (int i = 0; i < W; i++) begin
            if (s_r.s2[i] == s_r.s3[i]) begin
                s_nxt.q[i] = s_r.s3[i];
            end
        end
    end

    // reset values keep open pins at their safe reading until sampled
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q;

endmodule

/* drs_link.sv */
// serial command receiver and return shifter, run from sampled serial clock edges
`timescale 1ns/1ps
`include "drs_regs.svh"

module drs_link (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         sck,
    input  wire logic         csb_n,
    input  wire logic         si,
    input  wire logic         block,
    input  wire logic [15:0]  tx_word,
    output logic              so_out,
    output logic              so_oe_n,
    output logic              frame_valid,
    output logic              frame_drop,
    output logic [15:0]       frame_data
);
    import drs_pkg::*;

    drs_lnk_st_t s_r;
    drs_lnk_st_t s_nxt;
    logic        rise;
    logic        fall;

    // edges of the already synchronised serial clock
    assign rise = sck & ~s_r.sck_d;
    assign fall = ~sck & s_r.sck_d;

    // frame sequencing; while blocked the frame is swallowed and the return floats
    always_comb begin
        s_nxt             = s_r;
        s_nxt.sck_d       = sck;
        s_nxt.frame_valid = 1'b0;
        s_nxt.frame_drop  = 1'b0;
        case (s_r.state)
            DRS_LNK_IDLE: begin
                if (!csb_n) begin
                    s_nxt.bitcnt    = 5'h00;
                    s_nxt.shift_out = tx_word;
                    s_nxt.so        = tx_word[15];
                    s_nxt.state     = block ? DRS_LNK_HOLD : DRS_LNK_SHIFT; // R6
                end
            end
            DRS_LNK_SHIFT: begin
                if (block) begin
                    s_nxt.state = DRS_LNK_HOLD; // R6
                end else if (csb_n) begin
                    // only a whole frame counts as a command
                    s_nxt.frame_valid = (s_r.bitcnt == `DRS_FRAME_BITS);
                    s_nxt.frame_data  = s_r.shift_in;
                    s_nxt.state       = DRS_LNK_IDLE;
                end else begin
                    if (rise) begin
                        s_nxt.shift_in = {s_r.shift_in[14:0], si};
                        if (s_r.bitcnt != 5'h1F) begin
                            s_nxt.bitcnt = s_r.bitcnt + 5'h01;
                        end
                    end
                    if (fall) begin
                        s_nxt.shift_out = {s_r.shift_out[14:0], 1'b0};
                        s_nxt.so        = s_r.shift_out[14];
                    end
                end
            end
            DRS_LNK_HOLD: begin
                if (csb_n) begin
                    s_nxt.frame_drop = 1'b1; // R6
                    s_nxt.state      = DRS_LNK_IDLE;
                end
            end
            default: begin
                s_nxt.state = DRS_LNK_IDLE;
            end
        endcase
        s_nxt.so_oe_n = (s_nxt.state != DRS_LNK_SHIFT); // R6
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{state: DRS_LNK_IDLE, sck_d: 1'b0, bitcnt: 5'h00, shift_in: 16'h0000,
                     shift_out: 16'h0000, so: 1'b0, so_oe_n: 1'b1, frame_valid: 1'b0,
                     frame_drop: 1'b0, frame_data: 16'h0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign so_out      = s_r.so;
    assign so_oe_n     = s_r.so_oe_n;
    assign frame_valid = s_r.frame_valid;
    assign frame_drop  = s_r.frame_drop;
    assign frame_data  = s_r.frame_data;

    a_block_floats: assert property (@(posedge clock) disable iff (!rst_n) // R6
        block |=> so_oe_n)
        else $error("return pin driven while blocked");

    a_block_no_cmd: assert property (@(posedge clock) disable iff (!rst_n) // R6
        block |=> !frame_valid)
        else $error("frame accepted while blocked");

endmodule

/* drs_top.sv */
// reset, safe-state and slew control of a dual-channel solenoid current driver
//
// Overview of operation
// R1 - reset zeroes both current commands, outputs off, all settings to defaults
// R2 - reset also clears every fault bit
// R3 - after reset the outputs stay off until a valid command arrives
// R4 - logic supply undervoltage resets the block exactly like power-on reset
// R5 - while safe input is high, currents are zero and settings held at defaults
// R6 - while safe input is high, serial commands are dropped and return pin floats
// R7 - entering the safe state keeps every latched fault bit
// R8 - after the safe state ends, currents stay zero and settings default until commanded
// R9 - an open safe input reads high, so the block starts and stays safe
// R10 - the system holds the safe input high while the logic supply is low
// R11 - fault capture is off while the logic supply is below its operating level
// R12 - the factory check input is grounded; open it reads low and does nothing
// R13 - slew code 0 to 3 selects typical transitions of 0.5, 1, 2, 5 us
`timescale 1ns/1ps
`include "drs_regs.svh"

module drs_top (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         vdd_uv,
    input  wire logic         safe_in,
    input  wire logic         test_in,
    input  wire logic         supply_low_in,
    input  wire logic         sck,
    input  wire logic         csb_n,
    input  wire logic         si,
    output logic              so_out,
    output logic              so_oe_n,
    input  wire logic [3:0]   fault_evt,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    output logic              irq,
    output logic              low_side_output_one,
    output logic              low_side_output_two,
    output logic [9:0]        cur_cmd_one,
    output logic [9:0]        cur_cmd_two,
    output logic [1:0]        slew_sel,
    output logic [9:0]        slew_cycles
);
    import drs_pkg::*;

    // transition times in clock cycles, typical figures rounded down
    localparam logic [9:0] SLEW_CYC0 = 10'(`DRS_SLEW_T0_NS * 1000 / `DRS_CLK_PERIOD_PS);
    localparam logic [9:0] SLEW_CYC1 = 10'(`DRS_SLEW_T1_NS * 1000 / `DRS_CLK_PERIOD_PS);
    localparam logic [9:0] SLEW_CYC2 = 10'(`DRS_SLEW_T2_NS * 1000 / `DRS_CLK_PERIOD_PS);
    localparam logic [9:0] SLEW_CYC3 = 10'(`DRS_SLEW_T3_NS * 1000 / `DRS_CLK_PERIOD_PS);

    logic         rst_raw_n;
    logic         rst_s1;
    logic         rst_n;
    logic [5:0]   pins_s;
    logic         safe_s;
    logic         test_s;
    logic         suplo_s;
    logic         frame_valid;
    logic         frame_drop;
    logic [15:0]  frame_data;
    logic         acc;
    logic         rd_fault;
    logic         rd_irq;
    logic [3:0]   fault_set;
    logic [7:0]   irq_evt;
    logic [3:0]   state_word;
    drs_top_st_t  s_r;
    drs_top_st_t  s_nxt;

    // undervoltage joins the external reset, so both take the same path
    assign rst_raw_n = nrst & ~vdd_uv; // R4

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge rst_raw_n) begin
        if (!rst_raw_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // the serial, safe, test and supply-low pins pass the three-stage synchroniser; safe resets high
    drs_sync #(
        .W       (6),
        .RST_VAL (`DRS_SYNC_RST) // R9
    ) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({supply_low_in, test_in, safe_in, si, csb_n, sck}),
        .q     (pins_s)
    );

    assign safe_s  = pins_s[`DRS_SY_SAFE];
    assign test_s  = pins_s[`DRS_SY_TEST]; // R12
    assign suplo_s = pins_s[`DRS_SY_SUPLO];

    // serial command port; the fault word goes back on every frame taken while safe is low
    drs_link u_link (
        .clock       (clock),
        .rst_n       (rst_n),
        .sck         (pins_s[`DRS_SY_SCK]),
        .csb_n       (pins_s[`DRS_SY_CSB]),
        .si          (pins_s[`DRS_SY_SI]),
        .block       (safe_s), // R6
        .tx_word     ({12'h000, s_r.fault}),
        .so_out      (so_out),
        .so_oe_n     (so_oe_n),
        .frame_valid (frame_valid),
        .frame_drop  (frame_drop),
        .frame_data  (frame_data)
    );

    // bus address phase decode; single zero-wait slave
    assign acc      = hsel & hready & htrans[1];
    assign rd_fault = acc & ~hwrite & (haddr[7:0] == `DRS_OFF_FAULT);
    assign rd_irq   = acc & ~hwrite & (haddr[7:0] == `DRS_OFF_IRQ_ST);

    // faults are not trusted while the logic supply is low
    assign fault_set = fault_evt & {4{~suplo_s}}; // R11

    // sticky events: faults, safe entry and exit, frames taken and dropped
    assign irq_evt = {frame_drop, frame_valid, ~safe_s & s_r.safe_d, safe_s & ~s_r.safe_d,
                      fault_set};

    assign state_word = {suplo_s, s_r.cmd_valid, test_s, safe_s};

    // next state of the whole block
    always_comb begin
        s_nxt         = s_r;
        s_nxt.safe_d  = safe_s;
        s_nxt.wr_pend = acc & hwrite;
        s_nxt.wr_addr = haddr[7:0];

        // write data phase lands one cycle after its address phase
        if (s_r.wr_pend) begin
            case (s_r.wr_addr)
                `DRS_OFF_CUR_ONE: begin
                    s_nxt.cur1      = hwdata[`DRS_FR_DATA_HI:0];
                    s_nxt.cmd_valid = 1'b1; // R3
                end
                `DRS_OFF_CUR_TWO: begin
                    s_nxt.cur2      = hwdata[`DRS_FR_DATA_HI:0];
                    s_nxt.cmd_valid = 1'b1; // R3
                end
                `DRS_OFF_SLEW: begin
                    s_nxt.slew = hwdata[`DRS_FR_SLEW_HI:0]; // R13
                end
                `DRS_OFF_IRQ_MASK: begin
                    s_nxt.irq_mask = hwdata[7:0];
                end
                default: begin
                    s_nxt.wr_pend = s_nxt.wr_pend;
                end
            endcase
        end

        // a whole serial frame acts as a command
        if (frame_valid) begin
            case (frame_data[`DRS_FR_SEL_HI:`DRS_FR_SEL_LO])
                `DRS_SEL_CUR_ONE: begin
                    s_nxt.cur1      = frame_data[`DRS_FR_DATA_HI:0];
                    s_nxt.cmd_valid = 1'b1; // R3
                end
                `DRS_SEL_CUR_TWO: begin
                    s_nxt.cur2      = frame_data[`DRS_FR_DATA_HI:0];
                    s_nxt.cmd_valid = 1'b1; // R3
                end
                `DRS_SEL_SLEW: begin
                    s_nxt.slew = frame_data[`DRS_FR_SLEW_HI:0]; // R13
                end
                default: begin
                    s_nxt.cmd_valid = s_nxt.cmd_valid;
                end
            endcase
        end

        // safe state overrides every current and slew write and leaves the defaults behind on exit
        if (safe_s) begin
            s_nxt.cur1      = `DRS_CUR_RST; // R5
            s_nxt.cur2      = `DRS_CUR_RST; // R5
            s_nxt.slew      = `DRS_SLEW_RST; // R5
            s_nxt.cmd_valid = 1'b0; // R8
        end

        // fault bits: a new fault beats a clearing read; safe state never clears them
        s_nxt.fault  = (rd_fault ? `DRS_FAULT_RST : s_r.fault) | fault_set; // R7
        s_nxt.irq_st = (rd_irq ? `DRS_IRQ_RST : s_r.irq_st) | irq_evt;

        // read data registered at the address phase, shown in the data phase
        if (acc && !hwrite) begin
            case (haddr[7:0])
                `DRS_OFF_CUR_ONE:  s_nxt.rdata = {22'h000000, s_r.cur1};
                `DRS_OFF_CUR_TWO:  s_nxt.rdata = {22'h000000, s_r.cur2};
                `DRS_OFF_SLEW:     s_nxt.rdata = {30'h00000000, s_r.slew};
                `DRS_OFF_FAULT:    s_nxt.rdata = {28'h0000000, s_r.fault};
                `DRS_OFF_STATE:    s_nxt.rdata = {28'h0000000, state_word};
                `DRS_OFF_IRQ_ST:   s_nxt.rdata = {24'h000000, s_r.irq_st};
                `DRS_OFF_IRQ_MASK: s_nxt.rdata = {24'h000000, s_r.irq_mask};
                default:           s_nxt.rdata = `DRS_RDATA_RST;
            endcase
        end

        // gate drive only after a command, with nonzero current, outside the safe state
        s_nxt.drv1 = s_nxt.cmd_valid & (|s_nxt.cur1) & ~safe_s; // R3
        s_nxt.drv2 = s_nxt.cmd_valid & (|s_nxt.cur2) & ~safe_s; // R3

        // transition time that the output stage is told to use
        case (s_nxt.slew)
            2'h0:    s_nxt.slew_cyc = SLEW_CYC0; // R13
            2'h1:    s_nxt.slew_cyc = SLEW_CYC1; // R13
            2'h2:    s_nxt.slew_cyc = SLEW_CYC2; // R13
            default: s_nxt.slew_cyc = SLEW_CYC3; // R13
        endcase
    end

    // one register for the whole state; reset equals power-on defaults
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{cur1: `DRS_CUR_RST, cur2: `DRS_CUR_RST, slew: `DRS_SLEW_RST, // R1
                     cmd_valid: 1'b0, fault: `DRS_FAULT_RST, irq_st: `DRS_IRQ_RST, // R2
                     irq_mask: `DRS_IRQ_RST, safe_d: 1'b1, wr_pend: 1'b0,
                     wr_addr: 8'h00, rdata: `DRS_RDATA_RST, drv1: 1'b0, drv2: 1'b0,
                     slew_cyc: SLEW_CYC0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs; bus never stalls and never errors
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign hrdata              = s_r.rdata;
    assign irq                 = |(s_r.irq_st & s_r.irq_mask);
    assign low_side_output_one = s_r.drv1;
    assign low_side_output_two = s_r.drv2;
    assign cur_cmd_one         = s_r.cur1;
    assign cur_cmd_two         = s_r.cur2;
    assign slew_sel            = s_r.slew;
    assign slew_cycles         = s_r.slew_cyc;

    // exit from the safe state
    sequence s_safe_exit;
        $fell(safe_s);
    endsequence

    a_reset_defaults: assert property (@(posedge clock) disable iff (!rst_n) // R1
        $rose(rst_n) |-> cur_cmd_one == 10'h000 && cur_cmd_two == 10'h000
                         && slew_sel == 2'h0 && !low_side_output_one)
        else $error("settings not at default after reset");

    a_reset_faults: assert property (@(posedge clock) disable iff (!rst_n) // R2
        $rose(rst_n) |-> s_r.fault == 4'h0 && s_r.irq_st == 8'h00)
        else $error("fault bits survive reset");

    a_off_until_cmd: assert property (@(posedge clock) disable iff (!rst_n) // R3
        !s_r.cmd_valid |-> !low_side_output_one && !low_side_output_two)
        else $error("output active without a command");

    a_safe_zero: assert property (@(posedge clock) disable iff (!rst_n) // R5
        safe_s |=> cur_cmd_one == 10'h000 && cur_cmd_two == 10'h000 && slew_sel == 2'h0
                   && !low_side_output_one && !low_side_output_two)
        else $error("safe state leaves a channel commanded");

    a_fault_keep: assert property (@(posedge clock) disable iff (!rst_n) // R7
        safe_s && !rd_fault |=> (s_r.fault & $past(s_r.fault)) == $past(s_r.fault))
        else $error("fault bit lost in safe state");

    a_exit_default: assert property (@(posedge clock) disable iff (!rst_n) // R8
        s_safe_exit |-> cur_cmd_one == 10'h000 && cur_cmd_two == 10'h000 && !s_r.cmd_valid
                        ##1 slew_sel == 2'h0 || $past(s_r.wr_pend || frame_valid))
        else $error("settings changed on leaving safe state");

    a_lowsup_nodiag: assert property (@(posedge clock) disable iff (!rst_n) // R11
        suplo_s |=> (s_r.fault & ~$past(s_r.fault)) == 4'h0)
        else $error("fault captured with supply low");

    a_slew_map: assert property (@(posedge clock) disable iff (!rst_n) // R13
        slew_sel == 2'h3 |-> slew_cycles == 10'd625)
        else $error("slew code 3 not mapped to 5 us");

    a_drop_flag: assert property (@(posedge clock) disable iff (!rst_n) // R6
        frame_drop |=> s_r.irq_st[`DRS_IRQ_FRAME_DROP])
        else $error("dropped frame not flagged");

endmodule

/* drs_mcu.sv */
// behavioural serial master standing in for the microcontroller
`timescale 1ns/1ps

module drs_mcu (
    output logic        sck,
    output logic        csb_n,
    output logic        si,
    input  wire logic   so_out,
    input  wire logic   so_oe_n
);
    logic [15:0] rx;
    logic        drove;

    // idle: serial clock parked low, select high
    initial begin
        sck = 1'b0;
        csb_n = 1'b1;
        si = 1'b0;
        rx = 16'h0000;
        drove = 1'b0;
    end

    // one 16-bit frame, mode 0, 125 ns bit time, msb first
    task automatic send(input logic [15:0] w);
        drove = 1'b0;
        csb_n = 1'b0;
        #500;
        for (int i = 15; i >= 0; i--) begin
            si = w[i];
            #62.5;
            sck = 1'b1;
            // a floating return line reads as garbage, never as the last bit
            rx = {rx[14:0], so_oe_n ? ~so_out : so_out};
            drove = drove | ~so_oe_n;
            #62.5;
            sck = 1'b0;
        end
        #200;
        csb_n = 1'b1;
        si = ~si; // released line shows no stale bit
        #1000; // select high well past the sync latency
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the reset, safe-state and slew control
`timescale 1ns/1ps
`include "drs_regs.svh"

module testbench;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        vdd_uv = 1'b0;
    logic        safe_in = 1'b1; // open pin reads high
    logic        test_in = 1'b0; // grounded factory pin
    logic        supply_low_in = 1'b0;
    logic        sck, csb_n, si, so_out, so_oe_n, hreadyout, hresp, irq, hready;
    logic        low_side_output_one, low_side_output_two;
    logic [3:0]  fault_evt = 4'h0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0, slew_sel;
    logic [2:0]  hsize = 3'h2;
    logic [9:0]  cur_cmd_one, cur_cmd_two, slew_cycles;
    int          mismatches = 0;
    int          tests_run = 0;
    int          slew_ns[4] = '{`DRS_SLEW_T0_NS, `DRS_SLEW_T1_NS,
                                `DRS_SLEW_T2_NS, `DRS_SLEW_T3_NS};

    assign hready = hreadyout;

    drs_top drs_top_i (.clock, .nrst, .vdd_uv, .safe_in, .test_in, .supply_low_in, .sck, .csb_n,
        .si, .so_out, .so_oe_n, .fault_evt, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hrdata, .hresp, .irq, .low_side_output_one, .low_side_output_two,
        .cur_cmd_one, .cur_cmd_two, .slew_sel, .slew_cycles);

    drs_mcu drs_mcu_i (.sck, .csb_n, .si, .so_out, .so_oe_n);

    // 125 MHz system clock
    always #4 clock = ~clock;

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // single AHB-Lite word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // one-cycle fault event from the protection logic
    task automatic fault(input logic [3:0] f);
        fault_evt <= f;
        cyc(1);
        fault_evt <= 4'h0;
        cyc(1);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        cyc(3);
        nrst <= 1'b1;
        cyc(8);
        bus(0, `DRS_OFF_STATE, 0);
        chk(rd & 32'h1, 32'h1);
        chk({low_side_output_one, low_side_output_two, cur_cmd_one, slew_sel}, 0);
        safe_in <= 1'b0;
        cyc(8);
        bus(0, `DRS_OFF_STATE, 0);
        chk(rd, 0);
        chk({low_side_output_one, low_side_output_two}, 0);
        $display("test power-up done");
        bus(1, `DRS_OFF_CUR_ONE, 32'h155);
        cyc(1);
        chk({low_side_output_one, cur_cmd_one}, {1'b1, 10'h155});
        bus(1, `DRS_OFF_IRQ_MASK, 32'h40);
        bus(0, `DRS_OFF_IRQ_ST, 0);
        fault(4'h3);
        bus(0, `DRS_OFF_FAULT, 0);
        chk(rd, 32'h3);
        fault(4'h3);
        drs_mcu_i.send({2'h1, 4'h0, 10'h2AA});
        cyc(8);
        chk(drs_mcu_i.rx, 16'h0003);
        chk(cur_cmd_two, 10'h2AA);
        chk(irq, 1'b1);
        bus(0, `DRS_OFF_IRQ_ST, 0);
        cyc(1);
        chk(irq, 1'b0);
        bus(0, 8'h20, 0);
        chk(rd, 0);
        chk({hresp, hreadyout}, 2'h1);
        for (int k = 0; k < 4; k++) begin
            bus(1, `DRS_OFF_SLEW, k);
            cyc(1);
            chk(slew_sel, k);
            chk(slew_cycles, slew_ns[k] * 1000 / `DRS_CLK_PERIOD_PS);
        end
        $display("test command done");
        fault(4'h5);
        safe_in <= 1'b1;
        cyc(8);
        chk({low_side_output_one, low_side_output_two, cur_cmd_one, cur_cmd_two, slew_sel}, 0);
        bus(1, `DRS_OFF_CUR_ONE, 32'h3FF);
        cyc(1);
        chk(cur_cmd_one, 0);
        drs_mcu_i.send({2'h0, 4'h0, 10'h100});
        cyc(8);
        chk(drs_mcu_i.drove, 1'b0);
        chk(cur_cmd_one, 0);
        bus(0, `DRS_OFF_FAULT, 0);
        chk(rd & 32'h5, 32'h5);
        safe_in <= 1'b0;
        cyc(8);
        chk({low_side_output_one, cur_cmd_one, cur_cmd_two}, 0);
        bus(0, `DRS_OFF_SLEW, 0);
        chk(rd, 0);
        safe_in <= 1'b1;
        supply_low_in <= 1'b1;
        cyc(8);
        fault(4'h8);
        bus(0, `DRS_OFF_FAULT, 0);
        chk(rd, 0);
        safe_in <= 1'b0;
        supply_low_in <= 1'b0;
        $display("test safe state done");
        cyc(8);
        bus(1, `DRS_OFF_CUR_TWO, 32'h1);
        fault(4'h2);
        chk({low_side_output_two, cur_cmd_two}, {1'b1, 10'h001});
        vdd_uv <= 1'b1;
        cyc(2);
        vdd_uv <= 1'b0;
        cyc(8);
        chk({low_side_output_two, cur_cmd_two}, 0);
        bus(0, `DRS_OFF_FAULT, 0);
        chk(rd, 0);
        $display("test undervoltage done");
        end_of_test();
    end

    // watchdog: the whole sequence needs well under this span
    initial begin
        #300000;
        mismatches++;
        end_of_test();
    end
endmodule
